// ---- bbx_exec.sv ----
/*
 Execution unit for add, AND, bit clear, bit set and bit test-and-skip.
 Assumes one instruction per enabled ref_clk cycle, and a register file
 that returns the addressed byte combinationally on file_rdata; port pin
 levels arrive unsynchronised and pass two flip-flops here.
*/
`timescale 1ns/10ps
`include "bbx_map.svh"

module bbx_exec (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Instruction from fetch
  input wire bbx_pkg::bbx_instr_s instr,
  input wire logic instr_valid,
  // File register read side
  output logic [6:0] file_raddr,
  input wire logic [7:0] file_rdata,
  input wire logic file_is_port,
  input wire logic file_is_timer,
  input wire logic [7:0] port_pins,
  input wire logic prescaler_on_timer,
  // File register write side
  output logic file_we,
  output logic [6:0] file_waddr,
  output logic [7:0] file_wdata,
  output logic prescaler_clr,
  // Accumulator, flags and skip state
  output logic [7:0] acc,
  output bbx_pkg::bbx_flags_s flags,
  output logic skip_active
);
  // ==========================================================
  // Operand and result path
  // ==========================================================
  logic [7:0] operand;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] result;
  logic [7:0] bit_mask;
  logic bit_val;
  logic go;
  bbx_pkg::bbx_state_e state;
  bbx_pkg::bbx_state_e next_state;
  logic [7:0] next_acc;
  bbx_pkg::bbx_flags_s next_flags;
  logic next_we;
  logic [6:0] next_waddr;
  logic [7:0] next_wdata;
  logic next_pclr;
  logic next_skip;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;

  assign file_raddr = instr.addr;
  // Ignored fetch slot while the flushed instruction passes
  assign go = clk_en && instr_valid && (state == bbx_pkg::BBX_RUN);

  always_comb begin
    operand = file_is_port ? pin_sync : file_rdata;
    sum = {1'b0, acc} + {1'b0, (instr.op == bbx_pkg::BBX_ADD_LIT) ? instr.literal : operand};
    low_sum = {1'b0, acc[3:0]} + {1'b0, (instr.op == bbx_pkg::BBX_ADD_LIT) ? instr.literal[3:0] : operand[3:0]};
    bit_mask = 8'h01 << instr.bit_idx;
    bit_val = |(operand & bit_mask);
    result = 8'h00;
    next_acc = acc;
    next_flags = flags;
    next_we = 1'b0;
    next_waddr = instr.addr;
    next_wdata = 8'h00;
    next_state = bbx_pkg::BBX_RUN;
    if (go) begin
      case (instr.op)
        bbx_pkg::BBX_ADD_LIT, bbx_pkg::BBX_ADD_REG: begin
          result = sum[7:0];
          next_flags.c = sum[8];
          next_flags.half_carry_flag = low_sum[4];
          next_flags.z = (result == 8'h00);
        end
        bbx_pkg::BBX_AND_LIT: begin
          result = acc & instr.literal;
          next_flags.z = (result == 8'h00);
        end
        bbx_pkg::BBX_AND_REG: begin
          result = acc & operand;
          next_flags.z = (result == 8'h00);
        end
        bbx_pkg::BBX_BIT_CLR: begin
          next_we = 1'b1;
          next_wdata = operand & ~bit_mask;
        end
        bbx_pkg::BBX_BIT_SET: begin
          next_we = 1'b1;
          next_wdata = operand | bit_mask;
        end
        bbx_pkg::BBX_TEST: begin
          if (bit_val == instr.skip_if_one) begin
            next_state = bbx_pkg::BBX_FLUSH;
          end
        end
        default: begin
          result = 8'h00;
        end
      endcase
      if (instr.op == bbx_pkg::BBX_ADD_LIT || instr.op == bbx_pkg::BBX_AND_LIT) begin
        next_acc = result;
      end else if (instr.op == bbx_pkg::BBX_ADD_REG || instr.op == bbx_pkg::BBX_AND_REG) begin
        if (instr.dest == `BBX_DEST_ACC) begin
          next_acc = result;
        end else begin
          next_we = 1'b1;
          next_wdata = result;
        end
      end
    end else if (clk_en && state == bbx_pkg::BBX_FLUSH) begin
      next_state = bbx_pkg::BBX_RUN;
    end else if (!clk_en) begin
      next_state = state;
    end
    next_pclr = next_we && file_is_timer && prescaler_on_timer;
    next_skip = (next_state == bbx_pkg::BBX_FLUSH);
  end

  // ==========================================================
  // State registers
  // ==========================================================
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= bbx_pkg::BBX_RUN;
      acc <= `BBX_ACC_RESET;
      flags <= '0;
      file_we <= 1'b0;
      file_waddr <= 7'h00;
      file_wdata <= 8'h00;
      prescaler_clr <= 1'b0;
      skip_active <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      acc <= next_acc;
      flags <= next_flags;
      file_we <= next_we;
      file_waddr <= next_waddr;
      file_wdata <= next_wdata;
      prescaler_clr <= next_pclr;
      skip_active <= next_skip;
    end
  end

  // ==========================================================
  // Pin level synchroniser
  // ==========================================================
  // Only pin_sync feeds logic; pin_meta may be metastable
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else if (clk_en) begin
      pin_meta <= port_pins;
      pin_sync <= pin_meta;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  sequence taken_skip_s;
    go && instr.op == bbx_pkg::BBX_TEST && bit_val == instr.skip_if_one;
  endsequence

  sequence flush_slot_s;
    skip_active && !file_we && clk_en && !srst;
  endsequence

  add_carry_a: assert property (@(posedge ref_clk) disable iff (srst)
    go && instr.op == bbx_pkg::BBX_ADD_LIT |=> {flags.c, acc} == $past({1'b0, acc} + {1'b0, instr.literal}))
    else $error("add carry or sum wrong");
  add_flags_a: assert property (@(posedge ref_clk) disable iff (srst)
    go && instr.op == bbx_pkg::BBX_ADD_LIT |=> flags.z == (acc == 8'h00) &&
    flags.half_carry_flag == ($past({1'b0, acc[3:0]} + {1'b0, instr.literal[3:0]}) > 5'h0f))
    else $error("add zero or half carry wrong");
  add_reg_a: assert property (@(posedge ref_clk) disable iff (srst)
    go && instr.op == bbx_pkg::BBX_ADD_REG && instr.dest |=>
    file_we && file_wdata == $past(acc + operand) && $stable(acc))
    else $error("register add result wrong");
  dest_acc_a: assert property (@(posedge ref_clk) disable iff (srst)
    go && instr.op == bbx_pkg::BBX_AND_REG && !instr.dest |=> !file_we && acc == $past(acc & operand))
    else $error("destination select wrong");
  and_lit_a: assert property (@(posedge ref_clk) disable iff (srst)
    go && instr.op == bbx_pkg::BBX_AND_LIT |=> flags.c == $past(flags.c) && flags.z == (acc == 8'h00))
    else $error("literal AND flags wrong");
  and_reg_a: assert property (@(posedge ref_clk) disable iff (srst)
    go && instr.op == bbx_pkg::BBX_AND_REG |=> flags.half_carry_flag == $past(flags.half_carry_flag))
    else $error("register AND touched half carry");
  and_dest_a: assert property (@(posedge ref_clk) disable iff (srst)
    go && instr.op == bbx_pkg::BBX_AND_REG && instr.dest |=>
    file_we && file_wdata == $past(acc & operand) && $stable(acc))
    else $error("register AND write back wrong");
  bit_clr_a: assert property (@(posedge ref_clk) disable iff (srst)
    go && instr.op == bbx_pkg::BBX_BIT_CLR |=> file_we && file_wdata[$past(instr.bit_idx)] == 1'b0 && $stable(flags))
    else $error("bit clear wrong");
  bit_set_a: assert property (@(posedge ref_clk) disable iff (srst)
    go && instr.op == bbx_pkg::BBX_BIT_SET |=> file_we && file_wdata[$past(instr.bit_idx)] == 1'b1 && $stable(flags))
    else $error("bit set wrong");
  skip_enter_a: assert property (@(posedge ref_clk) disable iff (srst)
    taken_skip_s |=> skip_active && !file_we)
    else $error("taken skip did not open flush slot");
  skip_slot_a: assert property (@(posedge ref_clk) disable iff (srst)
    taken_skip_s ##1 flush_slot_s |=> !skip_active && !file_we)
    else $error("skip did not take two cycles");
  no_skip_a: assert property (@(posedge ref_clk) disable iff (srst)
    go && instr.op == bbx_pkg::BBX_TEST && bit_val != instr.skip_if_one |=> !skip_active && $stable(acc))
    else $error("untaken test skipped");
  discard_slot_a: assert property (@(posedge ref_clk) disable iff (srst)
    skip_active && clk_en && !srst |=> $stable(acc) && $stable(flags) && !file_we)
    else $error("flushed instruction executed");
  port_pins_a: assert property (@(posedge ref_clk) disable iff (srst)
    go && file_is_port && instr.op == bbx_pkg::BBX_BIT_SET |=> file_wdata == $past(pin_sync | bit_mask))
    else $error("port operand not from pins");
  presc_clr_a: assert property (@(posedge ref_clk) disable iff (srst)
    file_we && $past(file_is_timer && prescaler_on_timer && clk_en) |-> prescaler_clr)
    else $error("prescaler not cleared");
  presc_only_a: assert property (@(posedge ref_clk) disable iff (srst)
    prescaler_clr |-> file_we)
    else $error("prescaler clear without write");
  freeze_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    !clk_en && !srst |=> $stable(acc) && $stable(flags) && $stable(skip_active) && $stable(file_we))
    else $error("state moved while enable low");
endmodule

// ---- bbx_map.svh ----
/*
 Constants for the byte and bit operation execution unit.
 Assumes inclusion by bare name from the unit.
*/
// Summary of operation
// - Literal plus accumulator, sets carry, half-carry, zero
// - Accumulator plus file register, carry, half-carry, zero
// - Destination bit zero accumulator, one register
// - Literal AND accumulator, zero flag only
// - Register AND accumulator to destination, zero only
// - Bit clear in register, flags unchanged
// - Bit set in register, flags unchanged
// - Skip if one: bit set adds no-op cycle
// - Skip if zero: bit clear adds no-op cycle
// - Port operands read from pins, not latch
// - Timer count write clears assigned prescaler
`ifndef BBX_MAP_SVH
`define BBX_MAP_SVH
`define BBX_ACC_RESET 8'h00
`define BBX_FLAG_C 0
`define BBX_FLAG_HC 1
`define BBX_FLAG_Z 2
`define BBX_DEST_ACC 1'b0
`define BBX_DEST_REG 1'b1
`define BBX_SKIP_CYCLES 2
`endif

// ---- bbx_pkg.sv ----
/*
 Types for the byte and bit operation execution unit.
 Assumes no surroundings beyond the constants header.
*/
package bbx_pkg;
  typedef enum logic [7:0] {
    BBX_NOP = 8'h01,
    BBX_ADD_LIT = 8'h02,
    BBX_ADD_REG = 8'h04,
    BBX_AND_LIT = 8'h08,
    BBX_AND_REG = 8'h10,
    BBX_BIT_CLR = 8'h20,
    BBX_BIT_SET = 8'h40,
    BBX_TEST = 8'h80
  } bbx_op_e;

  typedef struct packed {
    bbx_op_e op;
    logic [7:0] literal;
    logic [6:0] addr;
    logic [2:0] bit_idx;
    logic dest;
    logic skip_if_one;
  } bbx_instr_s;

  typedef struct packed {
    logic z;
    logic half_carry_flag;
    logic c;
  } bbx_flags_s;

  typedef enum logic [1:0] {
    BBX_RUN = 2'h1,
    BBX_FLUSH = 2'h2
  } bbx_state_e;
endpackage

// ---- bbx_file_model.sv ----
/*
 File register partner model with one port and one timer address.
 Assumes the unit reads combinationally and writes one cycle later.
*/
`timescale 1ns/10ps
module bbx_file_model #(
  parameter logic [6:0] PORT_ADDR = 7'h06,
  parameter logic [6:0] TIMER_ADDR = 7'h01
) (
  // Read side
  input wire logic ref_clk,
  input wire logic [6:0] raddr,
  output logic [7:0] rdata,
  output logic is_port,
  output logic is_timer,
  // Write side
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata
);
  logic [7:0] mem [128];
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // Latch contents only, never pin levels
  assign rdata = mem[raddr];
  assign is_port = raddr == PORT_ADDR;
  assign is_timer = raddr == TIMER_ADDR;
  always @(posedge ref_clk) begin
    if (we) mem[waddr] <= wdata;
  end
endmodule

// ---- tb_top.sv ----
/*
 Self-checking bench for the execution unit.
 Assumes the register file model stands beside the unit.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin $display("MISMATCH %s exp %h got %h", n, e, g); failures++; end end
module tb_top;
  typedef struct packed {
    bbx_pkg::bbx_op_e op;
    logic [7:0] lit;
    logic [6:0] addr;
    logic [2:0] bidx;
    logic dest;
    logic [7:0] acc;
    logic [2:0] flags;
    logic we;
    logic [7:0] wd;
  } bbx_row_s;
  logic ref_clk = 0, srst = 1, clk_en = 1, instr_valid = 0, prescaler_on_timer = 0;
  bbx_pkg::bbx_instr_s instr = '0;
  logic [7:0] port_pins = 8'h00, file_rdata, file_wdata, acc, exp_acc;
  logic [6:0] file_raddr, file_waddr;
  logic file_is_port, file_is_timer, file_we, prescaler_clr, skip_active;
  bbx_pkg::bbx_flags_s flags;
  int failures = 0, num_checks = 0, cyc = 0;
  bbx_row_s rows [13];
  bbx_exec uut (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .instr(instr), .instr_valid(instr_valid),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_is_port(file_is_port), .file_is_timer(file_is_timer),
    .port_pins(port_pins), .prescaler_on_timer(prescaler_on_timer), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .prescaler_clr(prescaler_clr), .acc(acc), .flags(flags), .skip_active(skip_active));
  bbx_file_model fm (.ref_clk(ref_clk), .raddr(file_raddr), .rdata(file_rdata), .is_port(file_is_port),
    .is_timer(file_is_timer), .we(file_we), .waddr(file_waddr), .wdata(file_wdata));
  initial forever #2.5 ref_clk = ~ref_clk;
  // ==========================================
  // Drivers and verdict
  task automatic put(bbx_pkg::bbx_op_e op, logic [7:0] l, logic [6:0] a, logic [2:0] b, logic d, logic s);
    @(posedge ref_clk);
    instr <= '{op: op, literal: l, addr: a, bit_idx: b, dest: d, skip_if_one: s};
    instr_valid <= 1'b1;
  endtask
  task automatic done;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic give_verdict;
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      failures++;
      give_verdict();
    end
  end
  // ==========================================
  // Sequence
  initial begin
    rows = '{'{bbx_pkg::BBX_ADD_LIT, 8'h0f, 7'h00, 3'h0, 1'b0, 8'h0f, 3'b000, 1'b0, 8'h00},
      '{bbx_pkg::BBX_ADD_LIT, 8'h01, 7'h00, 3'h0, 1'b0, 8'h10, 3'b010, 1'b0, 8'h00},
      '{bbx_pkg::BBX_ADD_LIT, 8'hf0, 7'h00, 3'h0, 1'b0, 8'h00, 3'b101, 1'b0, 8'h00},
      '{bbx_pkg::BBX_ADD_LIT, 8'hff, 7'h00, 3'h0, 1'b0, 8'hff, 3'b000, 1'b0, 8'h00},
      '{bbx_pkg::BBX_ADD_LIT, 8'h02, 7'h00, 3'h0, 1'b0, 8'h01, 3'b011, 1'b0, 8'h00},
      '{bbx_pkg::BBX_AND_LIT, 8'hfe, 7'h00, 3'h0, 1'b0, 8'h00, 3'b111, 1'b0, 8'h00},
      '{bbx_pkg::BBX_BIT_SET, 8'h00, 7'h20, 3'h6, 1'b1, 8'h00, 3'b111, 1'b1, 8'hc1},
      '{bbx_pkg::BBX_BIT_CLR, 8'h00, 7'h20, 3'h7, 1'b1, 8'h00, 3'b111, 1'b1, 8'h41},
      '{bbx_pkg::BBX_ADD_REG, 8'h00, 7'h10, 3'h0, 1'b0, 8'h0f, 3'b000, 1'b0, 8'h00},
      '{bbx_pkg::BBX_ADD_REG, 8'h00, 7'h11, 3'h0, 1'b1, 8'h0f, 3'b000, 1'b1, 8'hff},
      '{bbx_pkg::BBX_AND_REG, 8'h00, 7'h20, 3'h0, 1'b1, 8'h0f, 3'b000, 1'b1, 8'h01},
      '{bbx_pkg::BBX_ADD_REG, 8'h00, 7'h11, 3'h0, 1'b0, 8'h0e, 3'b011, 1'b0, 8'h00},
      '{bbx_pkg::BBX_AND_REG, 8'h00, 7'h20, 3'h0, 1'b0, 8'h00, 3'b111, 1'b0, 8'h00}};
    repeat (8) @(posedge ref_clk);
    fm.mem[7'h10] = 8'h0f;
    fm.mem[7'h11] = 8'hf0;
    fm.mem[7'h20] = 8'h81;
    srst <= 1'b0;
    #1;
    `CHK("acc", 8'h00, acc)
    `CHK("flags", 3'b000, flags)
    foreach (rows[i]) begin
      put(rows[i].op, rows[i].lit, rows[i].addr, rows[i].bidx, rows[i].dest, 1'b0);
      done();
      `CHK("acc", rows[i].acc, acc)
      `CHK("flags", rows[i].flags, flags)
      `CHK("we", rows[i].we, file_we)
      if (rows[i].we) begin
        `CHK("wdata", rows[i].wd, file_wdata)
        `CHK("waddr", rows[i].addr, file_waddr)
      end
    end
    // Bit 0 of the tested byte is one, bit 1 is zero
    exp_acc = 8'h00;
    for (int k = 0; k < 4; k++) begin
      put(bbx_pkg::BBX_TEST, 8'h00, 7'h20, 3'(k[0]), 1'b0, k[1]);
      put(bbx_pkg::BBX_ADD_LIT, 8'h01, 7'h00, 3'h0, 1'b0, 1'b0);
      #1;
      `CHK("skip", ~k[0] == k[1], skip_active)
      done();
      if (~k[0] != k[1]) exp_acc = exp_acc + 8'h01;
      `CHK("acc", exp_acc, acc)
    end
    @(posedge ref_clk) port_pins <= 8'ha0;
    repeat (2) @(posedge ref_clk);
    put(bbx_pkg::BBX_BIT_SET, 8'h00, 7'h06, 3'h0, 1'b1, 1'b0);
    done();
    `CHK("port_we", 1'b1, file_we)
    `CHK("port", 8'ha1, file_wdata)
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk) prescaler_on_timer <= p[0];
      put(bbx_pkg::BBX_BIT_CLR, 8'h00, 7'h01, 3'h7, 1'b1, 1'b0);
      done();
      `CHK("pre_clr", p[0], prescaler_clr)
      `CHK("pre_we", 1'b1, file_we)
    end
    // Mid-run reset while a skip is pending
    put(bbx_pkg::BBX_ADD_LIT, 8'hff, 7'h00, 3'h0, 1'b0, 1'b0);
    done();
    `CHK("acc", 8'h01, acc)
    `CHK("flags", 3'b011, flags)
    put(bbx_pkg::BBX_TEST, 8'h00, 7'h20, 3'h0, 1'b0, 1'b1);
    @(posedge ref_clk) srst <= 1'b1;
    instr_valid <= 1'b0;
    #1;
    `CHK("skip", 1'b1, skip_active)
    @(posedge ref_clk) srst <= 1'b0;
    #1;
    `CHK("acc", 8'h00, acc)
    `CHK("flags", 3'b000, flags)
    `CHK("skip", 1'b0, skip_active)
    `CHK("we", 1'b0, file_we)
    put(bbx_pkg::BBX_ADD_LIT, 8'h05, 7'h00, 3'h0, 1'b0, 1'b0);
    done();
    `CHK("acc", 8'h05, acc)
    // Enable low holds the presented instruction
    put(bbx_pkg::BBX_ADD_LIT, 8'h10, 7'h00, 3'h0, 1'b0, 1'b0);
    clk_en <= 1'b0;
    @(posedge ref_clk) #1;
    `CHK("acc", 8'h05, acc)
    @(posedge ref_clk) clk_en <= 1'b1;
    done();
    `CHK("acc", 8'h15, acc)
    `CHK("flags", 3'b000, flags)
    give_verdict();
  end
endmodule
